// ==== design/fps_pkg.sv ====
/*
  Constants for the flash program/erase host controller.
  Assumes a byte-wide parallel flash with 19 address bits on the far side.
*/
package fps_pkg;
  localparam int         CLK_MHZ        = 25;                 // System clock rate
  localparam int         ADDR_W         = 19;                 // Flash address width
  localparam int         DATA_W         = 8;                  // Flash data width
  localparam logic [10:0] UNLOCK1_ADDR  = 11'h555;            // First unlock cycle address
  localparam logic [10:0] UNLOCK2_ADDR  = 11'h2aa;            // Second unlock cycle address
  localparam logic [7:0] UNLOCK1_DATA   = 8'haa;              // First unlock data
  localparam logic [7:0] UNLOCK2_DATA   = 8'h55;              // Second unlock data
  localparam logic [7:0] CMD_PROGRAM    = 8'ha0;              // Program setup
  localparam logic [7:0] CMD_ERASE      = 8'h80;              // Erase setup
  localparam logic [7:0] CMD_CHIP       = 8'h10;              // Chip erase data
  localparam logic [7:0] CMD_SECTOR     = 8'h30;              // Sector erase data / resume
  localparam logic [7:0] CMD_SUSPEND    = 8'hb0;              // Erase suspend
  localparam logic [7:0] CMD_RESET      = 8'hf0;              // Read/reset
  localparam logic [7:0] CMD_ID         = 8'h90;              // Electronic ID entry
  localparam logic [7:0] PROT_LOW_ADDR  = 8'h02;              // Protect-check low byte
  localparam int         DQ_POLL        = 7;                  // Data polling bit
  localparam int         DQ_FAIL        = 5;                  // Timeout-failure bit
  localparam int         DQ_WINDOW      = 3;                  // Window-expired bit
  // Strobe timing, in ns, and derived cycle counts (least times round up)
  localparam int         T_SETUP_NS     = 40;
  localparam int         T_PULSE_NS     = 80;
  localparam int         T_HOLD_NS      = 40;
  localparam int         T_READ_NS      = 120;
  localparam int         SETUP_CYC      = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int         PULSE_CYC      = (T_PULSE_NS * CLK_MHZ + 999) / 1000;
  localparam int         HOLD_CYC       = (T_HOLD_NS * CLK_MHZ + 999) / 1000;
  localparam int         READ_CYC       = (T_READ_NS * CLK_MHZ + 999) / 1000;
  // Host does not time sector-select spacing; it only reports expiry of the 50 us window
  localparam int         T_WINDOW_US    = 50;
  localparam int         WINDOW_CYC     = T_WINDOW_US * CLK_MHZ;
  localparam int         CNT_W          = 8;                  // Strobe phase counter width
  typedef enum logic [3:0] {
    FPS_CMD_PROGRAM,
    FPS_CMD_CHIP_ERASE,
    FPS_CMD_SECTOR_ERASE,
    FPS_CMD_ADD_SECTOR,
    FPS_CMD_SUSPEND,
    FPS_CMD_RESUME,
    FPS_CMD_RESET,
    FPS_CMD_READ,
    FPS_CMD_PROT_CHECK
  } fps_cmd_e;
endpackage

// ==== design/fps_bus_if.sv ====
/*
  Internal carrier between sequencer and pin cycle engine.
  Assumes one clock domain; the engine does one bus cycle per start.
*/
`timescale 1ns/1ps
`default_nettype none
interface fps_bus_if;
  logic                          start;      // One-cycle cycle request
  logic                          wr;         // 1 write, 0 read
  logic [fps_pkg::ADDR_W-1:0]    addr;       // Cycle address
  logic [fps_pkg::DATA_W-1:0]    wdata;      // Write data
  logic                          done;       // One-cycle completion
  logic [fps_pkg::DATA_W-1:0]    rdata;      // Captured read data
  modport seq (output start, output wr, output addr, output wdata,
               input done, input rdata);
  modport eng (input start, input wr, input addr, input wdata,
               output done, output rdata);
endinterface
`default_nettype wire

// ==== design/fps_cycle_engine.sv ====
/*
  Pin cycle engine: one asynchronous flash read or write per request.
  Assumes the flash data bus is shared; data pin enable is low while driving.
*/
`timescale 1ns/1ps
`default_nettype none
module fps_cycle_engine (
  input  wire logic                       i_clk,
  input  wire logic                       i_rst,
  fps_bus_if.eng                          bus,
  input  wire logic [fps_pkg::DATA_W-1:0] i_dq,
  output logic      [fps_pkg::DATA_W-1:0] o_dq,
  output logic                            o_dq_oe_n,
  output logic      [fps_pkg::ADDR_W-1:0] o_addr,
  output logic                            o_ce_n,
  output logic                            o_we_n,
  output logic                            o_oe_n
);
  typedef enum logic [2:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} fps_eng_e;
  fps_eng_e                        st_reg,   st_next;    // Phase
  logic [fps_pkg::CNT_W-1:0]       cnt_reg,  cnt_next;   // Phase counter
  logic                            wr_reg,   wr_next;    // Cycle kind
  logic [fps_pkg::ADDR_W-1:0]      a_reg,    a_next;     // Address pins
  logic [fps_pkg::DATA_W-1:0]      d_reg,    d_next;     // Drive data
  logic [fps_pkg::DATA_W-1:0]      rd_reg,   rd_next;    // Captured read
  logic [fps_pkg::DATA_W-1:0]      s1_reg, s2_reg, s3_reg; // Data synchroniser
  logic                            done_reg, done_next;  // Done pulse

  // Next-state logic for one strobe cycle
  always_comb begin
    st_next   = st_reg;
    cnt_next  = cnt_reg;
    wr_next   = wr_reg;
    a_next    = a_reg;
    d_next    = d_reg;
    rd_next   = rd_reg;
    done_next = 1'b0;
    case (st_reg)
      E_IDLE: begin
        if (bus.start) begin
          st_next  = E_SETUP;
          wr_next  = bus.wr;
          a_next   = bus.addr;
          d_next   = bus.wdata;
          cnt_next = fps_pkg::CNT_W'(fps_pkg::SETUP_CYC);
        end
      end
      E_SETUP: begin
        if (cnt_reg <= 1) begin
          st_next  = E_PULSE;
          // Reads wait out access time plus synchroniser depth
          cnt_next = wr_reg ? fps_pkg::CNT_W'(fps_pkg::PULSE_CYC)
                            : fps_pkg::CNT_W'(fps_pkg::READ_CYC + 3);
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      E_PULSE: begin
        if (cnt_reg <= 1) begin
          // Flash latches data on the rising edge of the write strobe
          st_next  = E_HOLD;
          cnt_next = fps_pkg::CNT_W'(fps_pkg::HOLD_CYC);
          // Pin data counts only once the last two stages agree
          if (!wr_reg && s2_reg == s3_reg) begin
            rd_next = s3_reg;
          end
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
      default: begin
        if (cnt_reg <= 1) begin
          st_next   = E_IDLE;
          done_next = 1'b1;
        end else begin
          cnt_next = cnt_reg - 1'b1;
        end
      end
    endcase
  end

  // Registers; data pins pass three flops before use
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      st_reg   <= E_IDLE;
      cnt_reg  <= '0;
      wr_reg   <= 1'b0;
      a_reg    <= '0;
      d_reg    <= '0;
      rd_reg   <= '0;
      done_reg <= 1'b0;
      s1_reg   <= '0;
      s2_reg   <= '0;
      s3_reg   <= '0;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      wr_reg   <= wr_next;
      a_reg    <= a_next;
      d_reg    <= d_next;
      rd_reg   <= rd_next;
      done_reg <= done_next;
      s1_reg   <= i_dq;
      s2_reg   <= s1_reg;
      s3_reg   <= s2_reg;
    end
  end

  // Pin outputs from state
  assign o_addr    = a_reg;
  assign o_dq      = d_reg;
  assign o_ce_n    = (st_reg == E_IDLE);
  assign o_we_n    = !(wr_reg && st_reg == E_PULSE);
  assign o_oe_n    = !(!wr_reg && st_reg == E_PULSE);
  assign o_dq_oe_n = !(wr_reg && st_reg != E_IDLE);
  assign bus.done  = done_reg;
  assign bus.rdata = rd_reg;
endmodule
`default_nettype wire

// ==== design/fps_host_sequencer.sv ====
/*
  Host-side sequencer that drives program and erase commands into a flash.
  Assumes one command at a time on the user port; flash on the engine pins.
*/
`timescale 1ns/1ps
`default_nettype none
module fps_host_sequencer (
  input  wire logic                       I_SYS_CLK,
  input  wire logic                       I_RST,
  input  wire logic                       I_REQ,
  input  wire logic [3:0]                 I_CMD,
  input  wire logic [fps_pkg::ADDR_W-1:0] I_ADDR,
  input  wire logic [fps_pkg::DATA_W-1:0] I_DATA,
  output logic                            O_BUSY,
  output logic                            O_DONE,
  output logic      [fps_pkg::DATA_W-1:0] O_RDATA,
  output logic                            O_FAIL,
  output logic                            O_WINDOW_EXPIRED,
  input  wire logic [fps_pkg::DATA_W-1:0] I_DQ,
  output logic      [fps_pkg::DATA_W-1:0] O_DQ,
  output logic                            O_DQ_OE_N,
  output logic      [fps_pkg::ADDR_W-1:0] O_ADDR,
  output logic                            O_CE_N,
  output logic                            O_WE_N,
  output logic                            O_OE_N
);
  typedef enum logic [2:0] {S_IDLE, S_ISSUE, S_WAIT, S_POLL, S_POLL_WAIT} fps_seq_e;

  fps_bus_if bus ();

  fps_seq_e                         st_reg,   st_next;    // Sequencer state
  logic [2:0]                       idx_reg,  idx_next;   // Write index in sequence
  logic [2:0]                       len_reg,  len_next;   // Sequence length
  fps_pkg::fps_cmd_e                cmd_reg,  cmd_next;   // Latched command
  logic [fps_pkg::ADDR_W-1:0]       adr_reg,  adr_next;   // Target address
  logic [fps_pkg::DATA_W-1:0]       dat_reg,  dat_next;   // Target data
  logic [fps_pkg::DATA_W-1:0]       rd_reg,   rd_next;    // Returned data
  logic                             fail_reg, fail_next;  // Failure seen
  logic                             win_reg,  win_next;   // Window expired seen
  logic                             done_reg, done_next;  // Done pulse
  logic                             poll_reg, poll_next;  // Sequence ends in polling
  logic                             st_start, st_wr;      // Engine request
  logic [fps_pkg::ADDR_W-1:0]       st_addr;
  logic [fps_pkg::DATA_W-1:0]       st_data;

  // Address and data of write number idx for a command
  function automatic logic [26:0] seq_word(input fps_pkg::fps_cmd_e c,
                                           input logic [2:0] i,
                                           input logic [fps_pkg::ADDR_W-1:0] a,
                                           input logic [fps_pkg::DATA_W-1:0] d);
    logic [fps_pkg::ADDR_W-1:0] wa;
    logic [fps_pkg::DATA_W-1:0] wd;
    // Command writes only set the low eleven bits
    wa = {8'h00, fps_pkg::UNLOCK1_ADDR};
    wd = fps_pkg::UNLOCK1_DATA;
    case (c)
      fps_pkg::FPS_CMD_PROGRAM: begin
        if (i == 3'd1) begin
          wa = {8'h00, fps_pkg::UNLOCK2_ADDR};
          wd = fps_pkg::UNLOCK2_DATA;
        end else if (i == 3'd2) begin
          wd = fps_pkg::CMD_PROGRAM;
        end else if (i == 3'd3) begin
          wa = a;
          wd = d;
        end
      end
      fps_pkg::FPS_CMD_CHIP_ERASE, fps_pkg::FPS_CMD_SECTOR_ERASE: begin
        if (i == 3'd1 || i == 3'd4) begin
          wa = {8'h00, fps_pkg::UNLOCK2_ADDR};
          wd = fps_pkg::UNLOCK2_DATA;
        end else if (i == 3'd2) begin
          wd = fps_pkg::CMD_ERASE;
        end else if (i == 3'd5 && c == fps_pkg::FPS_CMD_CHIP_ERASE) begin
          wd = fps_pkg::CMD_CHIP;
        end else if (i == 3'd5) begin
          // Sector in top three bits only
          wa = {a[18:16], 16'h0000};
          wd = fps_pkg::CMD_SECTOR;
        end
      end
      fps_pkg::FPS_CMD_ADD_SECTOR, fps_pkg::FPS_CMD_RESUME: begin
        // Single sector-select write; after suspend it resumes
        wa = {a[18:16], 16'h0000};
        // One write per request keeps added sectors tightly spaced
        wd = fps_pkg::CMD_SECTOR;
      end
      fps_pkg::FPS_CMD_SUSPEND: begin
        wd = fps_pkg::CMD_SUSPEND;
      end
      fps_pkg::FPS_CMD_RESET: begin
        wd = fps_pkg::CMD_RESET;
      end
      fps_pkg::FPS_CMD_PROT_CHECK: begin
        if (i == 3'd1) begin
          wa = {8'h00, fps_pkg::UNLOCK2_ADDR};
          wd = fps_pkg::UNLOCK2_DATA;
        end else if (i == 3'd2) begin
          wd = fps_pkg::CMD_ID;
        end else if (i == 3'd3) begin
          wa = {a[18:16], 8'h00, fps_pkg::PROT_LOW_ADDR};
        end else if (i == 3'd4) begin
          wd = fps_pkg::CMD_RESET;
        end
      end
      default: begin
        wa = a;
      end
    endcase
    return {wa, wd};
  endfunction

  // Sequence lengths per command
  function automatic logic [2:0] seq_len(input fps_pkg::fps_cmd_e c);
    case (c)
      fps_pkg::FPS_CMD_PROGRAM:      return 3'd4;
      fps_pkg::FPS_CMD_CHIP_ERASE,
      fps_pkg::FPS_CMD_SECTOR_ERASE: return 3'd6;
      fps_pkg::FPS_CMD_PROT_CHECK:   return 3'd5;
      default:                       return 3'd1;
    endcase
  endfunction

  // Sequencer next-state logic
  always_comb begin
    logic [26:0] w;
    w         = seq_word(cmd_reg, idx_reg, adr_reg, dat_reg);
    st_next   = st_reg;
    idx_next  = idx_reg;
    len_next  = len_reg;
    cmd_next  = cmd_reg;
    adr_next  = adr_reg;
    dat_next  = dat_reg;
    rd_next   = rd_reg;
    fail_next = fail_reg;
    win_next  = win_reg;
    poll_next = poll_reg;
    done_next = 1'b0;
    st_start  = 1'b0;
    st_wr     = 1'b1;
    st_addr   = w[26:8];
    st_data   = w[7:0];
    case (st_reg)
      S_IDLE: begin
        if (I_REQ) begin
          cmd_next  = fps_pkg::fps_cmd_e'(I_CMD);
          adr_next  = I_ADDR;
          dat_next  = I_DATA;
          idx_next  = 3'd0;
          len_next  = seq_len(fps_pkg::fps_cmd_e'(I_CMD));
          poll_next = (I_CMD == 4'(fps_pkg::FPS_CMD_PROGRAM)) ||
                      (I_CMD == 4'(fps_pkg::FPS_CMD_CHIP_ERASE));
          st_next   = S_ISSUE;
          if (I_CMD == 4'(fps_pkg::FPS_CMD_RESET)) begin
            fail_next = 1'b0;
          end
        end
      end
      S_ISSUE: begin
        st_start = 1'b1;
        st_wr    = !(cmd_reg == fps_pkg::FPS_CMD_READ ||
                     (cmd_reg == fps_pkg::FPS_CMD_PROT_CHECK && idx_reg == 3'd3));
        st_next  = S_WAIT;
      end
      S_WAIT: begin
        // Cycle kind must be known before the read data is taken
        st_wr   = !(cmd_reg == fps_pkg::FPS_CMD_READ ||
                    (cmd_reg == fps_pkg::FPS_CMD_PROT_CHECK && idx_reg == 3'd3));
        if (bus.done) begin
          if (!st_wr) begin
            rd_next = bus.rdata;
          end
          if (idx_reg + 3'd1 >= len_reg) begin
            // Device ignores commands while busy, so poll to completion
            st_next  = poll_reg ? S_POLL : S_IDLE;
            done_next = !poll_reg;
          end else begin
            idx_next = idx_reg + 3'd1;
            st_next  = S_ISSUE;
          end
        end
      end
      S_POLL: begin
        st_start = 1'b1;
        st_wr    = 1'b0;
        st_addr  = adr_reg;
        st_next  = S_POLL_WAIT;
      end
      default: begin
        st_wr   = 1'b0;
        st_addr = adr_reg;
        if (bus.done) begin
          rd_next = bus.rdata;
          // Polling bit true data means finished (erase reads ones)
          if (bus.rdata[fps_pkg::DQ_POLL] == (cmd_reg == fps_pkg::FPS_CMD_PROGRAM ?
                                              dat_reg[fps_pkg::DQ_POLL] : 1'b1)) begin
            st_next   = S_IDLE;
            done_next = 1'b1;
          end else if (bus.rdata[fps_pkg::DQ_FAIL]) begin
            // Failure stays until user issues reset
            fail_next = 1'b1;
            st_next   = S_IDLE;
            done_next = 1'b1;
          end else begin
            st_next = S_POLL;
          end
        end
      end
    endcase
    // Window expiry bit seen on any read, whatever the address, except under a chip erase command
    if (bus.done && !st_wr && bus.rdata[fps_pkg::DQ_WINDOW] &&
        cmd_reg != fps_pkg::FPS_CMD_CHIP_ERASE) begin
      win_next = 1'b1;
    end
    if (st_reg == S_IDLE && I_REQ) begin
      win_next = 1'b0;
    end
  end

  // Sequencer registers
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      st_reg   <= S_IDLE;
      idx_reg  <= '0;
      len_reg  <= '0;
      cmd_reg  <= fps_pkg::FPS_CMD_READ;
      adr_reg  <= '0;
      dat_reg  <= '0;
      rd_reg   <= '0;
      fail_reg <= 1'b0;
      win_reg  <= 1'b0;
      done_reg <= 1'b0;
      poll_reg <= 1'b0;
    end else begin
      st_reg   <= st_next;
      idx_reg  <= idx_next;
      len_reg  <= len_next;
      cmd_reg  <= cmd_next;
      adr_reg  <= adr_next;
      dat_reg  <= dat_next;
      rd_reg   <= rd_next;
      fail_reg <= fail_next;
      win_reg  <= win_next;
      done_reg <= done_next;
      poll_reg <= poll_next;
    end
  end

  assign bus.start = st_start;
  assign bus.wr    = st_wr;
  assign bus.addr  = st_addr;
  assign bus.wdata = st_data;

  // Strobe engine
  fps_cycle_engine u_eng (
    .i_clk     (I_SYS_CLK),
    .i_rst     (I_RST),
    .bus       (bus),
    .i_dq      (I_DQ),
    .o_dq      (O_DQ),
    .o_dq_oe_n (O_DQ_OE_N),
    .o_addr    (O_ADDR),
    .o_ce_n    (O_CE_N),
    .o_we_n    (O_WE_N),
    .o_oe_n    (O_OE_N)
  );

  assign O_BUSY           = (st_reg != S_IDLE);
  assign O_DONE           = done_reg;
  assign O_RDATA          = rd_reg;
  assign O_FAIL           = fail_reg;
  assign O_WINDOW_EXPIRED = win_reg;
endmodule
`default_nettype wire

// ==== verif/fps_flash_model.sv ====
/*
  Behavioural byte-wide flash seen by the host controller.
  Assumes the bench resolves the shared data bus from o_drive.
*/
`timescale 1ns/1ps
`default_nettype none
module fps_flash_model #(
  parameter logic [2:0] PROT_SEC = 3'h3  // Locked sector
) (
  input  wire logic [18:0] i_addr,
  input  wire logic [7:0]  i_dq,
  input  wire logic        i_ce_n,
  input  wire logic        i_we_n,
  input  wire logic        i_oe_n,
  output logic      [7:0]  o_dq,
  output logic             o_drive
);
  logic [7:0] mem [int];  // Array, absent bytes read erased
  logic [7:0] sel = 0;    // Erase buffer, one bit a sector
  logic [7:0] pd = 0;     // Last program value
  int         step = 0;   // Unlock progress
  int         ecnt = 0;   // Erase time left, us
  bit         busy, fail, idm, win, ers, chip, susp;
  time        wt = 0;     // Last sector write
  initial mem[19'h30010] = 8'h3c;  // Preset byte in the locked sector
  function automatic logic [7:0] rd(input logic [18:0] a);
    return mem.exists(a) ? mem[a] : 8'hff;
  endfunction
  // Read path, sampled often; strobe reads last far longer
  always #5 begin
    o_drive = !i_ce_n && !i_oe_n;
    if (busy || fail) o_dq = {~pd[7], 1'b0, fail, 5'h00};
    else if (ers || win) o_dq = {4'h0, ers && !chip, 3'h0};
    else if (idm && i_addr[7:0] == 8'h02) o_dq = {7'h00, i_addr[18:16] == PROT_SEC};
    else o_dq = rd(i_addr);
  end
  // Erase start: all-locked buffer idles longer, erases nothing
  task automatic go();
    win = 0;
    ers = 1;
    ecnt = ((sel & ~(8'h01 << PROT_SEC)) != 0) ? 20 : 100;
  endtask
  // Program only clears bits; a set attempt fails and holds
  task automatic prog(input logic [18:0] a, input logic [7:0] d);
    pd = d;
    if ((rd(a) & d) != d) fail = 1;
    else if (a[18:16] != PROT_SEC) begin
      mem[a] = d;
      busy = 1;
      #2000 busy = 0;
    end
  endtask
  // Command cycles, taken at the write strobe rise
  always @(posedge i_we_n) begin
    if (!i_ce_n) wr(i_addr, i_dq);
  end
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    logic [10:0] c;
    c = a[10:0];
    if (busy) return;
    if (ers) begin
      if (!chip && d == 8'hb0) susp = 1;
      else if (susp && d == 8'h30) susp = 0;
      return;
    end
    if (win) begin
      if (d == 8'h30) begin
        sel[a[18:16]] = 1;
        wt = $time;
        step = 0;
        if (susp) begin
          susp = 0;
          go();
        end
        return;
      end
      if (d == 8'hb0) begin
        susp = 1;
        return;
      end
      if (!(d == 8'haa || d == 8'h55 || d == 8'h80)) begin
        {win, susp, sel, step} = 0;
        return;
      end
    end
    if (d == 8'hf0) begin
      {fail, idm, step} = 0;
      return;
    end
    if (fail) return;
    case (step)
      0, 4: step = (c == 11'h555 && d == 8'haa) ? step + 1 : 0;
      1, 5: step = (c == 11'h2aa && d == 8'h55) ? step + 1 : 0;
      2: begin
        idm = (c == 11'h555 && d == 8'h90);
        step = (c != 11'h555) ? 0 : (d == 8'ha0) ? 3 : (d == 8'h80) ? 4 : 0;
      end
      3: begin
        step = 0;
        prog(a, d);
      end
      6: begin
        step = 0;
        if (d == 8'h10) {chip, ers, ecnt} = {2'b11, 32'd20};
        else if (d == 8'h30) {sel[a[18:16]], win, wt} = {2'b11, $time};
      end
      default: step = 0;
    endcase
  endtask
  // One tick a microsecond: window expiry, then erase progress
  always #1000 begin
    if (win && !susp && $time - wt >= 50000) go();
    if (ers && !susp && --ecnt == 0) begin
      foreach (mem[k]) if (k[18:16] != PROT_SEC && (chip || sel[k[18:16]])) mem[k] = 8'hff;
      {ers, chip, sel} = 0;
    end
  end
endmodule
`default_nettype wire

// ==== verif/fps_host_sequencer_props.sv ====
/*
  Pin and handshake checks for the host sequencer.
  Assumes binding onto the top module; one clock domain.
*/
`timescale 1ns/1ps
`default_nettype none
module fps_host_sequencer_props (
  input wire logic        I_SYS_CLK,
  input wire logic        I_RST,
  input wire logic        I_REQ,
  input wire logic        O_BUSY,
  input wire logic        O_DONE,
  input wire logic        O_CE_N,
  input wire logic        O_WE_N,
  input wire logic        O_OE_N,
  input wire logic        O_DQ_OE_N,
  input wire logic [18:0] O_ADDR,
  input wire logic [7:0]  O_DQ
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (I_RST);
  property p_done; O_DONE |=> !O_DONE; endproperty
  a_done: assert property (p_done) else $error("done longer than one cycle");
  property p_take; I_REQ && !O_BUSY |=> O_BUSY; endproperty
  a_take: assert property (p_take) else $error("request not taken");
  property p_we_ce; !O_WE_N |-> !O_CE_N && O_OE_N; endproperty
  a_we_ce: assert property (p_we_ce) else $error("write strobe without chip enable");
  property p_we_drv; !O_WE_N |-> !O_DQ_OE_N; endproperty
  a_we_drv: assert property (p_we_drv) else $error("write strobe with data undriven");
  property p_rd_drv; !O_OE_N |-> O_DQ_OE_N; endproperty
  a_rd_drv: assert property (p_rd_drv) else $error("bus fight on read");
  property p_width; $fell(O_WE_N) |=> !O_WE_N ##1 O_WE_N; endproperty
  a_width: assert property (p_width) else $error("write pulse not two cycles");
  property p_hold; !O_WE_N |=> $stable(O_ADDR) && $stable(O_DQ); endproperty
  a_hold: assert property (p_hold) else $error("address or data moved in pulse");
  property p_setup; $fell(O_WE_N) |-> !$past(O_CE_N); endproperty
  a_setup: assert property (p_setup) else $error("no setup before write");
  property p_idle; !O_BUSY |-> O_WE_N && O_OE_N; endproperty
  a_idle: assert property (p_idle) else $error("strobe while idle");
endmodule
bind fps_host_sequencer fps_host_sequencer_props u_props (
  .I_SYS_CLK(I_SYS_CLK), .I_RST(I_RST), .I_REQ(I_REQ), .O_BUSY(O_BUSY), .O_DONE(O_DONE),
  .O_CE_N(O_CE_N), .O_WE_N(O_WE_N), .O_OE_N(O_OE_N), .O_DQ_OE_N(O_DQ_OE_N),
  .O_ADDR(O_ADDR), .O_DQ(O_DQ));
`default_nettype wire

// ==== verif/fps_host_sequencer_tb.sv ====
/*
  Command-level bench for the host sequencer against a flash model.
  Assumes the package command codes and a 40 ns system clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fps_host_sequencer_tb;
  logic        clk = 0, rst = 1, req = 0;
  logic [3:0]  cmd_c = 0;
  logic [18:0] addr = 0;
  logic [7:0]  data = 0, last = 0;
  wire  [18:0] f_addr;
  wire  [7:0]  dq, o_dq, m_dq, rdata;
  wire         oe_n, we_n, ce_n, dq_oe_n, busy, done, fail, wexp, m_drv;
  int          errors = 0, n_tests = 0;
  always #20 clk = ~clk;
  // Released bus shows a changing pattern, not a stale value
  assign dq = m_drv ? m_dq : !dq_oe_n ? o_dq : ~last;
  always @(posedge clk) last <= dq;
  fps_host_sequencer u_dut (.I_SYS_CLK(clk), .I_RST(rst), .I_REQ(req), .I_CMD(cmd_c),
    .I_ADDR(addr), .I_DATA(data), .O_BUSY(busy), .O_DONE(done), .O_RDATA(rdata),
    .O_FAIL(fail), .O_WINDOW_EXPIRED(wexp), .I_DQ(dq), .O_DQ(o_dq), .O_DQ_OE_N(dq_oe_n),
    .O_ADDR(f_addr), .O_CE_N(ce_n), .O_WE_N(we_n), .O_OE_N(oe_n));
  fps_flash_model u_flash (.i_addr(f_addr), .i_dq(dq), .i_ce_n(ce_n), .i_we_n(we_n),
    .i_oe_n(oe_n), .o_dq(m_dq), .o_drive(m_drv));
  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin errors++; $display("mismatch %s expected %h seen %h", nm, e, g); end
  endtask
  task automatic chk1(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin errors++; $display("mismatch %s expected %b seen %b", nm, e, g); end
  endtask
  // One command, then a bounded wait for its done pulse
  task automatic run(input fps_pkg::fps_cmd_e c, input logic [18:0] a, input logic [7:0] d);
    int n;
    @(posedge clk);
    {req, cmd_c, addr, data} <= {1'b1, 4'(c), a, d};
    @(posedge clk);
    req <= 1'b0;
    n = 0;
    do begin @(posedge clk); #1; n++; end while (done !== 1'b1 && n < 5000);
    chk1("done", 1'b1, done);
  endtask
  task automatic report_and_stop();
    $display("errors %0d tests %0d", errors, n_tests);
    if (errors == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Whole run is well under half a millisecond
  initial begin #2_000_000; errors++; report_and_stop(); end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    run(fps_pkg::FPS_CMD_PROGRAM, 19'h01234, 8'ha5); chk1("fail", 1'b0, fail);
    run(fps_pkg::FPS_CMD_READ, 19'h01234, 8'h00); chk8("read", 8'ha5, rdata);
    run(fps_pkg::FPS_CMD_PROGRAM, 19'h01234, 8'hff); chk1("fail", 1'b1, fail);
    run(fps_pkg::FPS_CMD_RESET, 19'h00000, 8'h00); chk1("fail", 1'b0, fail);
    run(fps_pkg::FPS_CMD_READ, 19'h01234, 8'h00); chk8("read", 8'ha5, rdata);
    run(fps_pkg::FPS_CMD_PROT_CHECK, 19'h30000, 8'h00); chk8("prot", 8'h01, rdata);
    run(fps_pkg::FPS_CMD_PROT_CHECK, 19'h10000, 8'h00); chk8("prot", 8'h00, rdata);
    // Erase of sector 0 plus locked sector, suspended in the window
    run(fps_pkg::FPS_CMD_SECTOR_ERASE, 19'h0ffff, 8'h00);
    run(fps_pkg::FPS_CMD_ADD_SECTOR, 19'h37777, 8'h00);
    run(fps_pkg::FPS_CMD_SUSPEND, 19'h00000, 8'h00);
    run(fps_pkg::FPS_CMD_RESUME, 19'h00000, 8'h00);
    run(fps_pkg::FPS_CMD_READ, 19'h01234, 8'h00); chk1("window", 1'b1, wexp);
    repeat (1000) @(posedge clk);
    run(fps_pkg::FPS_CMD_READ, 19'h01234, 8'h00); chk8("erased", 8'hff, rdata);
    run(fps_pkg::FPS_CMD_READ, 19'h30010, 8'h00); chk8("locked", 8'h3c, rdata);
    // Locked sector alone: window runs out, nothing erased
    run(fps_pkg::FPS_CMD_SECTOR_ERASE, 19'h30000, 8'h00);
    run(fps_pkg::FPS_CMD_READ, 19'h30010, 8'h00); chk1("window", 1'b0, wexp);
    repeat (1500) @(posedge clk);
    run(fps_pkg::FPS_CMD_READ, 19'h30010, 8'h00); chk1("window", 1'b1, wexp);
    repeat (2600) @(posedge clk);
    run(fps_pkg::FPS_CMD_READ, 19'h30010, 8'h00); chk8("locked", 8'h3c, rdata);
    // Reset inside the window abandons the erase
    run(fps_pkg::FPS_CMD_PROGRAM, 19'h51111, 8'h81);
    run(fps_pkg::FPS_CMD_SECTOR_ERASE, 19'h50000, 8'h00);
    run(fps_pkg::FPS_CMD_RESET, 19'h00000, 8'h00);
    repeat (1500) @(posedge clk);
    run(fps_pkg::FPS_CMD_READ, 19'h51111, 8'h00); chk8("abort", 8'h81, rdata);
    run(fps_pkg::FPS_CMD_CHIP_ERASE, 19'h51111, 8'h00); chk1("window", 1'b0, wexp);
    run(fps_pkg::FPS_CMD_READ, 19'h51111, 8'h00); chk8("chip", 8'hff, rdata);
    run(fps_pkg::FPS_CMD_READ, 19'h30010, 8'h00); chk8("locked", 8'h3c, rdata);
    report_and_stop();
  end
endmodule
`default_nettype wire
